// [rtcsc_pkg.sv]
// package: register map, field layout and state types of the rtc status/control block
package rtcsc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] RTCSC_OFF_SC   = 5'h00;
  localparam logic [4:0] RTCSC_OFF_MOD  = 5'h04;
  localparam logic [4:0] RTCSC_OFF_CNT  = 5'h08;
  localparam logic [4:0] RTCSC_OFF_EVT  = 5'h0C;
  localparam logic [4:0] RTCSC_OFF_MASK = 5'h10;
  localparam int         RTCSC_AW       = 5;

  // ----------------------------------------------------------------
  // status/control field positions
  // ----------------------------------------------------------------
  localparam int RTCSC_CS_LSB   = 14;
  localparam int RTCSC_CS_MSB   = 15;
  localparam int RTCSC_PS_LSB   = 8;
  localparam int RTCSC_PS_MSB   = 10;
  localparam int RTCSC_FLAG_BIT = 7;
  localparam int RTCSC_IE_BIT   = 6;
  localparam int RTCSC_TOG_BIT  = 4;

  // event register bits
  localparam int RTCSC_EVT_MATCH = 0;
  localparam int RTCSC_EVT_CLR   = 1;
  localparam int RTCSC_EVT_W     = 2;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RTCSC_CS_EXT    = 2'h0;
  localparam logic [1:0]  RTCSC_CS_LPO    = 2'h1;
  localparam logic [1:0]  RTCSC_CS_IREF   = 2'h2;
  localparam logic [1:0]  RTCSC_CS_BUS    = 2'h3;
  localparam logic [2:0]  RTCSC_PS_OFF    = 3'h0;
  localparam logic [15:0] RTCSC_CNT_ZERO  = 16'h0000;
  localparam logic [15:0] RTCSC_MOD_RST   = 16'h0000;
  localparam logic        RTCSC_PIN_RST   = 1'h1;
  localparam int          RTCSC_DIV_W     = 11;
  localparam logic [1:0]  RTCSC_HTRANS_NS = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [2:0] prescale_select;
    logic       match_flag;
    logic       match_irq_enable;
    logic       toggle_out_enable;
  } rtcsc_ctrl_type;

  typedef struct packed {
    logic [RTCSC_DIV_W-1:0] div;
    logic                   tick;
  } rtcsc_pre_state_type;

  typedef struct packed {
    logic [2:0]             sync1;
    logic [2:0]             sync2;
    logic [2:0]             sync3;
    rtcsc_ctrl_type         sc;
    logic [15:0]            modulo;
    logic [15:0]            main_count;
    logic                   pin;
    logic [RTCSC_EVT_W-1:0] evt;
    logic [RTCSC_EVT_W-1:0] mask;
    logic                   wr_pend;
    logic [RTCSC_AW-1:0]    wr_addr;
    logic                   rd_sc;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic                   irq;
  } rtcsc_state_type;

endpackage

// [rtcsc_prescaler.sv]
// prescaler: divides source ticks by the selected binary or decimal ratio
`timescale 1ns/1ps
`default_nettype none

module rtcsc_prescaler
  import rtcsc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       src_tick,
  input  wire logic [2:0] prescale_select,
  input  wire logic       source_low_bit,
  input  wire logic       clear,
  output logic            tick
);

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  function automatic logic [RTCSC_DIV_W-1:0] rtcsc_last(input logic [2:0] ps,
                                                        input logic       low);
    logic [RTCSC_DIV_W:0] ratio;
    ratio = '0;
    if (!low) begin
      ratio = (RTCSC_DIV_W+1)'(1) << (ps - 3'h1);
    end else begin
      unique case (ps)
        3'h6:    ratio = (RTCSC_DIV_W+1)'(100);
        3'h7:    ratio = (RTCSC_DIV_W+1)'(1000);
        default: ratio = (RTCSC_DIV_W+1)'(128) << (ps - 3'h1);
      endcase
    end
    return RTCSC_DIV_W'(ratio - (RTCSC_DIV_W+1)'(1));
  endfunction

  rtcsc_pre_state_type st;
  rtcsc_pre_state_type next_st;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (clear || prescale_select == RTCSC_PS_OFF) begin
      next_st.div = '0;
    end else if (src_tick) begin
      if (st.div >= rtcsc_last(prescale_select, source_low_bit)) begin
        next_st.div  = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.div = st.div + RTCSC_DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  off_no_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (prescale_select == RTCSC_PS_OFF) |=> !tick)
    else $error("prescaler ticked while off");

  div_two_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (src_tick && !clear && prescale_select == 3'h2 && !source_low_bit && st.div == '0)
    |=> !tick)
    else $error("divide by two ticked on first source edge");

  div_two_tick_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (src_tick && !clear && prescale_select == 3'h2 && !source_low_bit
     && st.div == RTCSC_DIV_W'(1)) |=> tick)
    else $error("divide by two missed second source edge");

endmodule // rtcsc_prescaler

`default_nettype wire

// [rtcsc_top.sv]
// top: ahb-lite register slave, source select, counter, match flag and toggle pin
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// - source select code picks one of four clocks
// - reserved status/control bits read zero
// - changed prescale select clears divider and count
// - reset prescale off; off stops counting
// - source low bit 0: divide 1 to 64
// - source low bit 1: 128..2048, 100, 1000
// - match flag set when count reaches modulo
// - writing one clears flag and request
// - reset clears match flag and irq enable
// - irq enable raises request while flag set
// - toggle enable inverts pin on each overflow
// - source select bits 15:14, reset 00
// - on match count returns to zero
module rtcsc_top
  import rtcsc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_osc_clock,
  input  wire logic        low_power_osc_clock,
  input  wire logic        internal_ref_clock,
  output logic             counter_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rtcsc_sc_word(input rtcsc_ctrl_type c);
    logic [31:0] w;
    w = '0;
    w[RTCSC_CS_MSB:RTCSC_CS_LSB] = c.clock_source_select;
    w[RTCSC_PS_MSB:RTCSC_PS_LSB] = c.prescale_select;
    w[RTCSC_FLAG_BIT]            = c.match_flag;
    w[RTCSC_IE_BIT]              = c.match_irq_enable;
    w[RTCSC_TOG_BIT]             = c.toggle_out_enable;
    return w;
  endfunction

  // unmapped offsets and every reserved bit read back as zero
  function automatic logic [31:0] rtcsc_read(input rtcsc_state_type s,
                                             input logic [RTCSC_AW-1:0] a);
    logic [31:0] w;
    w = '0;
    unique case (a)
      RTCSC_OFF_SC:   w = rtcsc_sc_word(s.sc);
      RTCSC_OFF_MOD:  w[15:0] = s.modulo;
      RTCSC_OFF_CNT:  w[15:0] = s.main_count;
      RTCSC_OFF_EVT:  w[RTCSC_EVT_W-1:0] = s.evt;
      RTCSC_OFF_MASK: w[RTCSC_EVT_W-1:0] = s.mask;
      default:        w = '0;
    endcase
    return w;
  endfunction

  rtcsc_state_type st;
  rtcsc_state_type next_st;
  logic            src_tick;
  logic            pre_clear;
  logic            ps_tick;
  logic            wrap;
  logic            addr_ok;
  logic [2:0]      src_rise;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // divider runs on clk_sys; slow sources reach it only as one-cycle ticks,
  // so no source can count faster than the system clock
  rtcsc_prescaler u_prescaler (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .src_tick        (src_tick),
    .prescale_select (st.sc.prescale_select),
    .source_low_bit  (st.sc.clock_source_select[0]),
    .clear           (pre_clear),
    .tick            (ps_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st   = st;
    pre_clear = 1'b0;
    wrap      = 1'b0;
    addr_ok   = hsel && htrans == RTCSC_HTRANS_NS && hready;

    // slow clocks are only sampled; edges are seen after two flops
    next_st.sync1 = {ext_osc_clock, low_power_osc_clock, internal_ref_clock};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    src_rise      = st.sync2 & ~st.sync3;

    unique case (st.sc.clock_source_select)
      RTCSC_CS_EXT:  src_tick = src_rise[2];
      RTCSC_CS_LPO:  src_tick = src_rise[1];
      RTCSC_CS_IREF: src_tick = src_rise[0];
      RTCSC_CS_BUS:  src_tick = 1'b1;
    endcase

    // data phase of a write; hsize is ignored, every access is a whole word
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        RTCSC_OFF_SC: begin
          next_st.sc.clock_source_select = hwdata[RTCSC_CS_MSB:RTCSC_CS_LSB];
          next_st.sc.prescale_select     = hwdata[RTCSC_PS_MSB:RTCSC_PS_LSB];
          next_st.sc.match_irq_enable    = hwdata[RTCSC_IE_BIT];
          next_st.sc.toggle_out_enable   = hwdata[RTCSC_TOG_BIT];
          if (hwdata[RTCSC_FLAG_BIT]) begin
            next_st.sc.match_flag = 1'b0;
          end
          // an equal rewrite of either select must not restart the count
          pre_clear = (hwdata[RTCSC_CS_MSB:RTCSC_CS_LSB] != st.sc.clock_source_select)
                   || (hwdata[RTCSC_PS_MSB:RTCSC_PS_LSB] != st.sc.prescale_select);
        end
        RTCSC_OFF_MOD:  next_st.modulo = hwdata[15:0];
        RTCSC_OFF_EVT:  next_st.evt    = st.evt & ~hwdata[RTCSC_EVT_W-1:0];
        RTCSC_OFF_MASK: next_st.mask   = hwdata[RTCSC_EVT_W-1:0];
        default:        next_st.modulo = st.modulo;
      endcase
    end

    // counting; a set arriving with a clear wins
    if (pre_clear) begin
      next_st.main_count          = RTCSC_CNT_ZERO;
      next_st.evt[RTCSC_EVT_CLR]  = 1'b1;
    end else if (ps_tick) begin
      if (st.main_count == st.modulo) begin
        wrap                          = 1'b1;
        next_st.main_count            = RTCSC_CNT_ZERO;
        next_st.sc.match_flag         = 1'b1;
        next_st.evt[RTCSC_EVT_MATCH]  = 1'b1;
        if (st.sc.toggle_out_enable) begin
          next_st.pin = ~st.pin;
        end
      end else begin
        next_st.main_count = st.main_count + 16'h0001;
      end
    end

    // address phase
    next_st.wr_pend = addr_ok && hwrite;
    next_st.wr_addr = {haddr[RTCSC_AW-1:2], 2'h0};
    next_st.rd_sc   = addr_ok && !hwrite && next_st.wr_addr == RTCSC_OFF_SC;
    if (addr_ok && !hwrite) begin
      // read sees the preceding write, so no wait state is needed
      next_st.hrdata = rtcsc_read(next_st, next_st.wr_addr);
    end
    next_st.hreadyout = 1'b1;
    next_st.hresp     = 1'b0;

    // match source and event sources share the one level output
    next_st.irq = (next_st.sc.match_flag && next_st.sc.match_irq_enable)
               || |(next_st.evt & next_st.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st            <= '0;
      st.modulo     <= RTCSC_MOD_RST;
      st.pin        <= RTCSC_PIN_RST;
      st.hreadyout  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata      = st.hrdata;
  assign hreadyout   = st.hreadyout;
  assign hresp       = st.hresp;
  assign counter_out = st.pin;
  assign irq         = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence rtcsc_wrap_s;
    wrap;
  endsequence

  sequence rtcsc_ext_rise_s;
    st.sc.clock_source_select == RTCSC_CS_EXT && src_rise[2];
  endsequence

  sequence rtcsc_iref_rise_s;
    st.sc.clock_source_select == RTCSC_CS_IREF && src_rise[0];
  endsequence

  sequence rtcsc_sc_write_s;
    st.wr_pend && st.wr_addr == RTCSC_OFF_SC;
  endsequence

  sequence rtcsc_flag_clr_s;
    st.wr_pend && st.wr_addr == RTCSC_OFF_SC && hwdata[RTCSC_FLAG_BIT];
  endsequence

  ext_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rtcsc_ext_rise_s and (st.sc.prescale_select == 3'h1 && !pre_clear)) |=> ps_tick)
    else $error("external source edge gave no tick at divide one");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.rd_sc |-> (st.hrdata[31:16] == 16'h0000 && st.hrdata[13:11] == 3'h0
                  && !st.hrdata[5] && st.hrdata[3:0] == 4'h0))
    else $error("reserved status bits read nonzero");

  change_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pre_clear |=> st.main_count == RTCSC_CNT_ZERO)
    else $error("count not cleared on select change");

  off_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st.sc.prescale_select == RTCSC_PS_OFF && $past(st.sc.prescale_select) == RTCSC_PS_OFF
     && !pre_clear) |=> $stable(st.main_count))
    else $error("count moved while prescaler off");

  match_wrap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_wrap_s |=> (st.main_count == RTCSC_CNT_ZERO && st.sc.match_flag))
    else $error("match did not wrap count and set flag");

  count_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ps_tick && !pre_clear && st.main_count != st.modulo)
    |=> st.main_count == $past(st.main_count) + 16'h0001)
    else $error("count did not advance by one");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rtcsc_flag_clr_s and !wrap)
    |=> (!st.sc.match_flag && (!irq || |(st.evt & st.mask))))
    else $error("write one did not clear flag");

  irq_raise_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st.sc.match_flag && st.sc.match_irq_enable) |-> irq)
    else $error("irq low while enabled flag set");

  pin_toggle_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rtcsc_wrap_s and st.sc.toggle_out_enable) |=> counter_out != $past(counter_out))
    else $error("pin did not toggle on overflow");

  pin_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !st.sc.toggle_out_enable |=> $stable(counter_out))
    else $error("pin moved with toggle disabled");

  // ----------------------------------------------------------------
  // checks: source routing, field writes and flag paths
  // ----------------------------------------------------------------
  ext_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st.sc.clock_source_select == RTCSC_CS_EXT && st.sc.prescale_select == 3'h1
     && !src_rise[2]) |=> !ps_tick)
    else $error("tick without an external source edge");

  iref_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rtcsc_iref_rise_s and (st.sc.prescale_select == 3'h1 && !pre_clear)) |=> ps_tick)
    else $error("reference source edge gave no tick at divide one");

  cs_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_sc_write_s
    |=> st.sc.clock_source_select == $past(hwdata[RTCSC_CS_MSB:RTCSC_CS_LSB]))
    else $error("source select write lost");

  ps_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_sc_write_s
    |=> st.sc.prescale_select == $past(hwdata[RTCSC_PS_MSB:RTCSC_PS_LSB]))
    else $error("prescale select write lost");

  ie_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_sc_write_s |=> st.sc.match_irq_enable == $past(hwdata[RTCSC_IE_BIT]))
    else $error("irq enable write lost");

  tog_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_sc_write_s |=> st.sc.toggle_out_enable == $past(hwdata[RTCSC_TOG_BIT]))
    else $error("toggle enable write lost");

  mod_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st.wr_pend && st.wr_addr == RTCSC_OFF_MOD) |=> st.modulo == $past(hwdata[15:0]))
    else $error("modulo write lost");

  sc_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    st.rd_sc |-> (st.hrdata[RTCSC_CS_MSB:RTCSC_CS_LSB] == st.sc.clock_source_select
                  && st.hrdata[RTCSC_PS_MSB:RTCSC_PS_LSB] == st.sc.prescale_select))
    else $error("status read shows wrong selects");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (st.sc.match_flag
     && !(st.wr_pend && st.wr_addr == RTCSC_OFF_SC && hwdata[RTCSC_FLAG_BIT]))
    |=> st.sc.match_flag)
    else $error("flag dropped without a write of one");

  flag_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!st.sc.match_flag && !wrap) |=> !st.sc.match_flag)
    else $error("flag set without a match");

  irq_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!(st.sc.match_flag && st.sc.match_irq_enable) && !(|(st.evt & st.mask))) |-> !irq)
    else $error("irq high with no enabled source");

  tick_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!ps_tick && !pre_clear) |=> $stable(st.main_count))
    else $error("count moved without a prescaler tick");

  event_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pre_clear |=> st.evt[RTCSC_EVT_CLR])
    else $error("select change event not raised");

  match_event_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rtcsc_wrap_s |=> (st.evt[RTCSC_EVT_MATCH] && st.sc.match_flag))
    else $error("match event not raised");

  pin_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !wrap |=> $stable(counter_out))
    else $error("pin moved without an overflow");

endmodule // rtcsc_top

`default_nettype wire

// [tb_rtc_status_control.sv]
// testbench: bus-driven checks of the rtc status/control block
`timescale 1ns/1ps
`default_nettype none

module tb_rtc_status_control
  import rtcsc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and clocks
  // ----------------------------------------------------------------
  logic        clk_sys  = 1'b0;
  logic        reset_n  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ext_clk  = 1'b0;
  logic        lpo_clk  = 1'b0;
  logic        iref_clk = 1'b0;
  logic        counter_out;
  logic        irq;
  int          miscompares = 0;
  int          cmp_count   = 0;
  logic [31:0] q;
  logic        p;
  int          n;
  int          div0 [7] = '{1, 2, 4, 8, 16, 32, 64};
  int          div1 [7] = '{128, 256, 512, 1024, 2048, 100, 1000};

  // source periods of 4, 8 and 6 cycles; edges avoid clk_sys rising edges
  always #2 clk_sys = ~clk_sys;
  always #8 ext_clk = ~ext_clk;
  always #16 lpo_clk = ~lpo_clk;
  always #12 iref_clk = ~iref_clk;

  rtcsc_top dut_u (
    .clk_sys             (clk_sys),
    .reset_n             (reset_n),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .ext_osc_clock       (ext_clk),
    .low_power_osc_clock (lpo_clk),
    .internal_ref_clock  (iref_clk),
    .counter_out         (counter_out),
    .irq                 (irq)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stuck(input string what);
    miscompares++;
    $display("mismatch %s expected done seen timeout", what);
    close_out();
  endtask

  // one ahb-lite single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int k;
    k = 0;
    hsel   <= 1'b1;
    htrans <= RTCSC_HTRANS_NS;
    haddr  <= {27'h0, a};
    hwrite <= wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) stuck("bus ready");
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0000_0000, v);
  endtask

  // cycles until counter_out changes level
  task automatic wait_pin(output int c);
    logic lvl;
    lvl = counter_out;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (counter_out === lvl && c < 5000);
    if (c >= 5000) stuck("pin toggle");
  endtask

  // first interval may be partial after the write, so the second is judged
  task automatic measure(input logic [1:0] cs, input logic [2:0] ps, input logic [15:0] m,
                         input int exp);
    int c;
    wr(RTCSC_OFF_MOD, {16'h0000, m});
    wr(RTCSC_OFF_SC, {16'h0000, cs, 3'h0, ps, 8'h10});
    wait_pin(c);
    wait_pin(c);
    check("pin period", exp, c);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (100) @(posedge clk_sys);
    rd(RTCSC_OFF_SC, q);
    check("sc reset", 32'h0000_0000, q);
    rd(RTCSC_OFF_CNT, q);
    check("count idle", 32'h0000_0000, q);
    check("pin reset", 32'h1, {31'h0, counter_out});
    check("irq reset", 32'h0, {31'h0, irq});
    $display("test reset done");

    wr(RTCSC_OFF_SC, 32'hFFFF_FFFF);
    rd(RTCSC_OFF_SC, q);
    check("sc reserved", 32'h0000_C750, q);
    rd(5'h1C, q);
    check("unmapped", 32'h0000_0000, q);
    wr(RTCSC_OFF_SC, 32'h0000_0000);
    wr(RTCSC_OFF_CNT, 32'h0000_1234);
    rd(RTCSC_OFF_CNT, q);
    check("count ro", 32'h0000_0000, q);
    $display("test fields done");

    for (int i = 1; i < 8; i++) begin
      measure(2'h0, i[2:0], 16'h0000, div0[i-1] * 4);
      measure(2'h2, i[2:0], 16'h0000, div0[i-1] * 6);
      measure(2'h3, i[2:0], 16'h0000, div1[i-1]);
    end
    measure(2'h1, 3'h1, 16'h0000, 128 * 8);
    measure(2'h0, 3'h1, 16'h0002, 12);
    $display("test dividers done");

    wr(RTCSC_OFF_MOD, 32'h0000_FFFF);
    wr(RTCSC_OFF_SC, 32'h0000_C100);
    repeat (600) @(posedge clk_sys);
    rd(RTCSC_OFF_CNT, q);
    check("count running", 32'h1, {31'h0, q != 32'h0});
    wr(RTCSC_OFF_SC, 32'h0000_C200);
    rd(RTCSC_OFF_CNT, q);
    check("count cleared", 32'h0000_0000, q);
    wr(RTCSC_OFF_MOD, 32'h0000_0000);
    p = counter_out;
    repeat (600) @(posedge clk_sys);
    check("pin held", {31'h0, p}, {31'h0, counter_out});
    $display("test clear done");

    // flag is left set by earlier runs; clear it so the match is really awaited
    wr(RTCSC_OFF_SC, 32'h0000_C1C0);
    rd(RTCSC_OFF_SC, q);
    check("flag before match", 32'h0000_C140, q);
    check("irq before match", 32'h0, {31'h0, irq});
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 1000) stuck("irq on match");
    check("irq on match", 32'h1, {31'h0, irq});
    wr(RTCSC_OFF_SC, 32'h0000_C040);
    rd(RTCSC_OFF_SC, q);
    check("flag kept", 32'h0000_C0C0, q);
    check("irq kept", 32'h1, {31'h0, irq});
    wr(RTCSC_OFF_SC, 32'h0000_C0C0);
    rd(RTCSC_OFF_SC, q);
    check("flag cleared", 32'h0000_C040, q);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(RTCSC_OFF_SC, 32'h0000_C100);
    repeat (300) @(posedge clk_sys);
    rd(RTCSC_OFF_SC, q);
    check("flag polled", 32'h0000_0080, q & 32'h0000_0080);
    check("irq disabled", 32'h0, {31'h0, irq});
    $display("test flag done");

    // select change raises event bit1; mask gates it onto irq
    wr(RTCSC_OFF_SC, 32'h0000_C080);
    rd(RTCSC_OFF_EVT, q);
    check("event set", 32'h0000_0002, q & 32'h0000_0002);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(RTCSC_OFF_MASK, 32'h0000_0002);
    rd(RTCSC_OFF_MASK, q);
    check("mask", 32'h0000_0002, q);
    check("irq event", 32'h1, {31'h0, irq});
    wr(RTCSC_OFF_EVT, 32'h0000_0003);
    rd(RTCSC_OFF_EVT, q);
    check("event cleared", 32'h0000_0000, q);
    check("irq off", 32'h0, {31'h0, irq});
    $display("test events done");
    close_out();
  end

endmodule // tb_rtc_status_control

`default_nettype wire
